// [bench/far_side_model.sv]
module far_side_model (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic clk_cpu_i,
  input wire logic sync_req_i,
  input wire logic ready_req_i,
  input wire logic ready_slow_i,
  output logic external_freq_input_o,
  output logic clock_sync_in_o,
  output logic bus1_ready_in_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic sync_q;
  logic cpu_q;
  logic efi_div;
  logic [1:0] rises;
  wire cpu_rose = clk_cpu_i && !cpu_q;
  wire [1:0] rises_needed = ready_slow_i ? 2'h2 : 2'h1;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      efi_div <= 1'b0;
      external_freq_input_o <= 1'b0;
      sync_q <= 1'b0;
      clock_sync_in_o <= 1'b0;
      cpu_q <= 1'b0;
      rises <= 2'h0;
      bus1_ready_in_o <= 1'b0;
    end else begin
      efi_div <= ~efi_div;
      external_freq_input_o <= external_freq_input_o ^ efi_div;
      sync_q <= sync_req_i;
      clock_sync_in_o <= sync_q;
      cpu_q <= clk_cpu_i;
      if (!ready_req_i) begin
        rises <= 2'h0;
        bus1_ready_in_o <= 1'b0;
      end else if (cpu_rose && rises != rises_needed) begin
        rises <= rises + 2'h1;
        bus1_ready_in_o <= (rises + 2'h1) == rises_needed;
      end
    end
  end
endmodule

// [bench/tb_top.sv]
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {logic wr; logic [3:0] addr; logic [31:0] data; logic [31:0] exp;} row_t;
  logic clk_sys_i = 0, rst_i = 1, src_sel = 0, spd = 1, sync_req = 0, rdy_req = 0, rdy_slow = 0;
  logic bus2_ready_in = 0, q1n = 1, q2n = 1, depth = 1, wr = 0, rd = 0, pv, ov;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic cpu, half, per, osc, rdy, external_freq_input, clock_sync_in, bus1_ready_in;
  int n_fail = 0, check_count = 0, cyc = 0, cpu_hi, half_hi, per_hi, rises, bad;
  localparam logic [3:0] CA = clock_gen_pkg::CTRL_ADDR;
  localparam logic [3:0] SA = clock_gen_pkg::STATUS_ADDR;
  row_t rows [8] = '{'{1'b0, SA, 32'h0, 32'h0}, '{1'b0, 4'h8, 32'h0, 32'h0},
    '{1'b1, 4'h8, 32'h1, 32'h0}, '{1'b0, CA, 32'h0, 32'h0}, '{1'b1, CA, 32'h1, 32'h0},
    '{1'b0, SA, 32'h0, 32'h1}, '{1'b1, CA, 32'h3, 32'h0}, '{1'b0, CA, 32'h0, 32'h0}};

  clock_gen_ready_sync clock_gen_ready_sync_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .freq_source_sel_i(src_sel),
    .external_freq_input_i(external_freq_input), .speed_select_i(spd), .clock_sync_in_i(clock_sync_in),
    .bus1_ready_in_i(bus1_ready_in), .bus2_ready_in_i(bus2_ready_in), .bus1_ready_qualify_n_i(q1n),
    .bus2_ready_qualify_n_i(q2n), .ready_sync_depth_sel_i(depth), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .clk_cpu_o(cpu),
    .clock_half_duty_o(half), .clk_periph_o(per), .osc_buffer_out_o(osc), .ready_o(rdy));

  far_side_model far_side_model_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .clk_cpu_i(cpu), .sync_req_i(sync_req),
    .ready_req_i(rdy_req), .ready_slow_i(rdy_slow), .external_freq_input_o(external_freq_input),
    .clock_sync_in_o(clock_sync_in), .bus1_ready_in_o(bus1_ready_in));

  initial begin
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end

  task automatic finish_test;
    $display("counts: checks=%0d fails=%0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 10000) begin
      n_fail++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask

  task automatic bus(input row_t r);
    @(posedge clk_sys_i);
    wr <= r.wr;
    rd <= !r.wr;
    addr <= r.addr;
    wdata <= r.data;
    @(posedge clk_sys_i);
    wr <= 1'b0;
    rd <= 1'b0;
    #1;
    if (!r.wr) check(rdata, r.exp);
  endtask

  task automatic run(input int n, input bit fast);
    logic pc, ph, pp;
    {pc, ph, pp} = {cpu, half, per};
    {cpu_hi, half_hi, per_hi, rises, bad} = '0;
    repeat (n) begin
      @(posedge clk_sys_i);
      #1;
      cpu_hi += cpu;
      half_hi += half;
      per_hi += per;
      rises += cpu && !pc;
      bad += ((pc && !cpu) != (ph && !half)) || (fast && pp && !per && !(pc && !cpu));
      {pc, ph, pp} = {cpu, half, per};
    end
  endtask

  task automatic ready_falls(input logic v, input int exp_falls);
    int f;
    logic pc;
    #1;
    f = 0;
    pc = cpu;
    repeat (40) begin
      @(posedge clk_sys_i);
      #1;
      if (pc && !cpu) f++;
      if (rdy === v) break;
      pc = cpu;
    end
    check(f, exp_falls);
    check(rdy, v);
    check(pc && !cpu, 1'b1);
  endtask

  task automatic bus1_ready(input logic d, input int exp_falls);
    @(posedge clk_sys_i);
    depth <= d;
    rdy_req <= 1'b1;
    repeat (20) if (bus1_ready_in !== 1'b1) step(1);
    ready_falls(1'b1, exp_falls);
    @(posedge clk_sys_i);
    rdy_req <= 1'b0;
    ready_falls(1'b0, 1);
  endtask

  initial begin
    repeat (11) @(posedge clk_sys_i);
    #1;
    check(rdata, 32'h0);
    check({cpu, half, per, osc, rdy}, 5'b01100);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    step(10);
    run(36, 1);
    check(cpu_hi, 12);
    check(half_hi, 18);
    check(per_hi, 18);
    check(rises, 6);
    check(bad, 0);
    $display("test fast done");
    foreach (rows[i]) bus(rows[i]);
    $display("test registers done");
    bus('{1'b1, CA, 32'h1, 32'h0});
    step(3);
    {pv, ov} = {per, osc};
    run(20, 0);
    check(cpu_hi + half_hi, 40);
    check(per_hi, pv ? 20 : 0);
    check(osc, ov);
    bus('{1'b1, CA, 32'h2, 32'h0});
    step(14);
    run(36, 1);
    check(cpu_hi, 12);
    check(bad, 0);
    $display("test stop done");
    @(posedge clk_sys_i);
    sync_req <= 1'b1;
    step(4);
    run(20, 0);
    check(cpu_hi + half_hi + per_hi, 60);
    @(posedge clk_sys_i);
    sync_req <= 1'b0;
    step(20);
    $display("test sync done");
    @(posedge clk_sys_i);
    q1n <= 1'b1;
    rdy_req <= 1'b1;
    step(30);
    check(rdy, 1'b0);
    @(posedge clk_sys_i);
    rdy_req <= 1'b0;
    step(3);
    @(posedge clk_sys_i);
    q1n <= 1'b0;
    bus1_ready(1'b1, 1);
    bus1_ready(1'b0, 2);
    @(posedge clk_sys_i);
    rdy_slow <= 1'b1;
    bus1_ready(1'b0, 2);
    @(posedge clk_sys_i);
    q1n <= 1'b1;
    q2n <= 1'b0;
    bus2_ready_in <= 1'b1;
    depth <= 1'b1;
    ready_falls(1'b1, 1);
    @(posedge clk_sys_i);
    bus2_ready_in <= 1'b0;
    ready_falls(1'b0, 1);
    $display("test ready done");
    @(posedge clk_sys_i);
    spd <= 1'b0;
    step(100);
    bus('{1'b0, SA, 32'h0, 32'h0});
    step(400);
    bus('{1'b0, SA, 32'h0, 32'h2});
    run(1536, 0);
    check(cpu_hi, 512);
    check(half_hi, 768);
    check(per_hi, 768);
    check(rises, 1);
    @(posedge clk_sys_i);
    spd <= 1'b1;
    step(20);
    bus('{1'b0, SA, 32'h0, 32'h0});
    $display("test slow done");
    @(posedge clk_sys_i);
    rst_i <= 1'b1;
    src_sel <= 1'b1;
    step(2);
    @(posedge clk_sys_i);
    rst_i <= 1'b0;
    step(20);
    run(48, 1);
    check(cpu_hi, 16);
    check(half_hi, 24);
    check(per_hi, 24);
    check(rises, 4);
    bus('{1'b1, CA, 32'h1, 32'h0});
    step(4);
    ov = osc;
    step(1);
    check({osc, cpu, half}, {~ov, 2'b11});
    $display("test external done");
    finish_test();
  end
endmodule

// [inc/clock_gen_pkg.sv]
package clock_gen_pkg;

  // register port
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [3:0] CTRL_ADDR = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam int CTRL_STOP_BIT = 0;
  localparam int CTRL_START_BIT = 1;
  localparam int ST_HALT_BIT = 0;
  localparam int ST_SLOW_BIT = 1;
  localparam int ST_READY_BIT = 2;
  localparam int ST_SYNC_BIT = 3;
  localparam logic [31:0] RDATA_RESET = 32'h0000_0000;

  // divider chain, counted in oscillator transitions (two per base cycle)
  localparam logic [3:0] CLK_DIV_MOD = 4'h6;
  localparam logic [3:0] PCLK_DIV_MOD = 4'hc;
  localparam logic [3:0] CNT_RESET_VAL = 4'h0;
  localparam logic [3:0] CNT_CLEAR_VAL = 4'h1;
  localparam logic [3:0] CLK_HIGH_FIRST = 4'h1;
  localparam logic [3:0] CLK_HIGH_LAST = 4'h2;
  localparam logic [3:0] HALF_HIGH_FIRST = 4'h0;
  localparam logic [3:0] HALF_HIGH_LAST = 4'h2;
  localparam logic [3:0] PCLK_LOW_FIRST = 4'h3;
  localparam logic [3:0] PCLK_LOW_LAST = 4'h8;
  localparam logic [3:0] PCLK_PRE_FALL = 4'h2;
  localparam logic [3:0] PCLK_PRE_RISE = 4'h8;
  localparam logic [3:0] PHASE_AT_PCLK_EDGE = 4'h3;
  localparam logic [7:0] SLOW_PRESCALE_LAST = 8'hff;
  localparam logic [7:0] PRESCALE_RESET = 8'h00;

  // speed_select filter, in base clock pulses
  localparam logic [7:0] SLOW_LOW_PULSES = 8'hc3;
  localparam logic [1:0] FAST_HIGH_PULSES = 2'h3;

  typedef enum logic {SPEED_FAST, SPEED_SLOW} speed_t;

endpackage

// [rtl/clock_gen_ready_sync.sv]
// Functional notes
// - a strap picks crystal oscillator or external input as base frequency
// - with external input selected the oscillator output keeps running
// - two synchronous divide-by-three counters, each with an inhibiting clear
// - processor clock one-third high, companion clock half high
// - processor and companion clocks fall on the same oscillator transition
// - peripheral clock is base/6 with even duty
// - peripheral clock rate ignores speed_select
// - stop freezes peripheral clock level until reset, start or clock_sync_in
// - in fast mode peripheral clock falls together with processor and companion clocks
// - clock_sync_in holds all three clocks high
// - each bus ready counts only with its own low qualifier
// - a valid qualified ready drives ready output high
// - shallow select low: rise caught on clock rise, ready on next fall
// - shallow select low: ready falling goes straight to stage two
// - shallow select high: only stage two on processor clock fall
// - stop in crystal mode halts oscillator too, processor and companion clocks stop high
// - slow after 195 low pulses, fast after 3 high pulses
// - recognised speed change applies at the next peripheral clock edge
//
// The address map and the strobed register port were chosen for this implementation.
module clock_gen_ready_sync (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic freq_source_sel_i,
  input wire logic external_freq_input_i,
  input wire logic speed_select_i,
  input wire logic clock_sync_in_i,
  input wire logic bus1_ready_in_i,
  input wire logic bus2_ready_in_i,
  input wire logic bus1_ready_qualify_n_i,
  input wire logic bus2_ready_qualify_n_i,
  input wire logic ready_sync_depth_sel_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic clk_cpu_o,
  output logic clock_half_duty_o,
  output logic clk_periph_o,
  output logic osc_buffer_out_o,
  output logic ready_o
);

  function automatic logic in_span(input logic [3:0] v, input logic [3:0] lo,
                                   input logic [3:0] hi);
    in_span = (v >= lo) && (v <= hi);
  endfunction

  logic strap_done;
  logic src_ext;
  logic stopped;
  logic efi_q;
  logic efi_prev;
  logic [7:0] low_cnt;
  logic [1:0] high_cnt;
  logic target_slow;
  clock_gen_pkg::speed_t speed;
  logic [7:0] prescale;
  logic ready_stage1;
  logic [3:0] cpu_phase;
  logic [3:0] half_phase;
  logic [3:0] pclk_cnt;

  // strap caught once after reset release
  // source strap capture
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      strap_done <= 1'b0;
      src_ext <= 1'b0;
    end else if (!strap_done) begin
      strap_done <= 1'b1;
      src_ext <= freq_source_sel_i;
    end
  end

  // start/stop commands, start wins
  wire ctrl_wr = reg_wr_i && (reg_addr_i == clock_gen_pkg::CTRL_ADDR);
  wire start_cmd = ctrl_wr && reg_wdata_i[clock_gen_pkg::CTRL_START_BIT];
  wire stop_cmd = ctrl_wr && reg_wdata_i[clock_gen_pkg::CTRL_STOP_BIT];
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stopped <= 1'b0;
    end else if (start_cmd) begin
      stopped <= 1'b0;
    end else if (stop_cmd) begin
      stopped <= 1'b1;
    end
  end

  // oscillator: one transition per system clock
  // oscillator halts on stop in crystal mode
  wire osc_run = strap_done && !(stopped && !src_ext);
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      osc_buffer_out_o <= 1'b0;
    end else if (osc_run) begin
      osc_buffer_out_o <= !osc_buffer_out_o;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      efi_q <= 1'b0;
      efi_prev <= 1'b0;
    end else begin
      efi_q <= external_freq_input_i;
      efi_prev <= efi_q;
    end
  end

  wire efi_tick = efi_q != efi_prev;
  wire efi_rise = efi_q && !efi_prev;
  wire base_tick = strap_done && (src_ext ? efi_tick : osc_run);
  wire base_rise = strap_done && (src_ext ? efi_rise : (osc_run && !osc_buffer_out_o));

  // speed_select filter
  // low/high pulse counts
  wire [7:0] next_low_cnt = speed_select_i ? 8'h00 :
    (low_cnt == clock_gen_pkg::SLOW_LOW_PULSES) ? low_cnt : low_cnt + 8'h01;
  wire [1:0] next_high_cnt = !speed_select_i ? 2'h0 :
    (high_cnt == clock_gen_pkg::FAST_HIGH_PULSES) ? high_cnt : high_cnt + 2'h1;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      low_cnt <= 8'h00;
      high_cnt <= 2'h0;
    end else if (base_rise) begin
      low_cnt <= next_low_cnt;
      high_cnt <= next_high_cnt;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      target_slow <= 1'b0;
    end else if (low_cnt == clock_gen_pkg::SLOW_LOW_PULSES) begin
      target_slow <= 1'b1;
    end else if (high_cnt == clock_gen_pkg::FAST_HIGH_PULSES) begin
      target_slow <= 1'b0;
    end
  end

  // counters advance; sync clears, stop holds
  wire sync_active = clock_sync_in_i;
  wire run = base_tick && !stopped && !sync_active;
  wire is_slow = speed == clock_gen_pkg::SPEED_SLOW;
  wire cpu_step = run && (!is_slow || prescale == clock_gen_pkg::SLOW_PRESCALE_LAST);
  // switch on the step into a peripheral clock edge
  wire pclk_edge_next = run && (pclk_cnt == clock_gen_pkg::PCLK_PRE_FALL ||
                                pclk_cnt == clock_gen_pkg::PCLK_PRE_RISE);
  wire speed_switch = pclk_edge_next && (is_slow != target_slow);
  wire align_load = speed_switch && !target_slow;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      speed <= clock_gen_pkg::SPEED_FAST;
      prescale <= clock_gen_pkg::PRESCALE_RESET;
    end else begin
      if (speed_switch) begin
        speed <= target_slow ? clock_gen_pkg::SPEED_SLOW : clock_gen_pkg::SPEED_FAST;
      end
      if (speed_switch || sync_active) begin
        prescale <= clock_gen_pkg::PRESCALE_RESET;
      end else if (run && is_slow) begin
        prescale <= prescale + 8'h01;
      end
    end
  end

  div_counter #(.MOD(clock_gen_pkg::CLK_DIV_MOD)) cpu_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .count_en_i(cpu_step),
    .clear_i(sync_active),
    .load_i(align_load),
    .load_val_i(clock_gen_pkg::PHASE_AT_PCLK_EDGE),
    .count_o(cpu_phase)
  );

  div_counter #(.MOD(clock_gen_pkg::CLK_DIV_MOD)) half_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .count_en_i(cpu_step),
    .clear_i(sync_active),
    .load_i(align_load),
    .load_val_i(clock_gen_pkg::PHASE_AT_PCLK_EDGE),
    .count_o(half_phase)
  );

  // peripheral counter runs on every base transition unless stopped or in sync
  div_counter #(.MOD(clock_gen_pkg::PCLK_DIV_MOD)) pclk_div (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .count_en_i(run),
    .clear_i(sync_active),
    .load_i(1'b0),
    .load_val_i(clock_gen_pkg::CNT_RESET_VAL),
    .count_o(pclk_cnt)
  );

  // duty decode, both fall entering phase 3
  wire dec_cpu = in_span(cpu_phase, clock_gen_pkg::CLK_HIGH_FIRST,
                         clock_gen_pkg::CLK_HIGH_LAST);
  wire dec_half = in_span(half_phase, clock_gen_pkg::HALF_HIGH_FIRST,
                          clock_gen_pkg::HALF_HIGH_LAST);
  // low from count 3, with cpu phase 3
  wire dec_pclk = !in_span(pclk_cnt, clock_gen_pkg::PCLK_LOW_FIRST,
                           clock_gen_pkg::PCLK_LOW_LAST);

  // sync forces high; stop holds processor clocks high
  wire force_high = sync_active || stopped;
  wire next_cpu = force_high || dec_cpu;
  wire next_half = force_high || dec_half;
  wire next_pclk = sync_active || (stopped ? clk_periph_o : dec_pclk);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      clk_cpu_o <= 1'b0;
      clock_half_duty_o <= 1'b1;
      clk_periph_o <= 1'b1;
    end else begin
      clk_cpu_o <= next_cpu;
      clock_half_duty_o <= next_half;
      clk_periph_o <= next_pclk;
    end
  end

  // ready synchronisation
  // qualified ready per bus
  wire rdy_valid = (bus1_ready_in_i && !bus1_ready_qualify_n_i) ||
                   (bus2_ready_in_i && !bus2_ready_qualify_n_i);
  wire clk_rise = next_cpu && !clk_cpu_o;
  wire clk_fall = !next_cpu && clk_cpu_o;
  // falling ready straight to stage two; stage one bypass
  wire next_ready = ready_sync_depth_sel_i ? rdy_valid : (ready_stage1 && rdy_valid);

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      ready_stage1 <= 1'b0;
      ready_o <= 1'b0;
    end else begin
      if (clk_rise) begin
        ready_stage1 <= rdy_valid;
      end
      if (clk_fall) begin
        ready_o <= next_ready;
      end
    end
  end

  // register reads, data in the following cycle only
  wire [31:0] status_word = {28'h000_0000, sync_active, ready_o, is_slow, stopped};
  wire [31:0] ctrl_word = {31'h0000_0000, stopped};
  wire [31:0] read_word = (reg_addr_i == clock_gen_pkg::STATUS_ADDR) ? status_word :
                          (reg_addr_i == clock_gen_pkg::CTRL_ADDR) ? ctrl_word :
                          clock_gen_pkg::RDATA_RESET;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      reg_rdata_o <= clock_gen_pkg::RDATA_RESET;
    end else begin
      reg_rdata_o <= reg_rd_i ? read_word : clock_gen_pkg::RDATA_RESET;
    end
  end

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);

  chk_stop_clocks_high: assert property (stopped |=> clk_cpu_o && clock_half_duty_o)
    else $error("clocks not high while stopped");
  chk_stop_pclk_frozen: assert property (stopped |=> clk_periph_o == $past(clk_periph_o))
    else $error("peripheral clock moved while stopped");
  chk_sync_all_high: assert property (sync_active |=>
    clk_cpu_o && clock_half_duty_o && clk_periph_o)
    else $error("clock not high during sync");
  chk_neg_edge_align: assert property ($fell(clock_half_duty_o) |-> $fell(clk_cpu_o))
    else $error("companion fell without processor clock");
  chk_pclk_fall_align: assert property ($fell(clk_periph_o) && !is_slow && !$past(is_slow)
    |-> $fell(clk_cpu_o))
    else $error("peripheral clock fell out of step");
  chk_ready_only_fall: assert property ($changed(ready_o) |-> $past(clk_fall))
    else $error("ready changed off processor clock fall");
  chk_ready_two_stage: assert property ($rose(ready_o) && !$past(ready_sync_depth_sel_i)
    |-> $past(ready_stage1))
    else $error("ready rose without first stage");
  chk_ready_drop: assert property (clk_fall && !rdy_valid |=> !ready_o)
    else $error("ready stayed high after ready input fell");
  chk_ready_shallow: assert property (clk_fall && ready_sync_depth_sel_i && rdy_valid
    |=> ready_o)
    else $error("qualified ready not passed");
  chk_slow_recognise: assert property (low_cnt == clock_gen_pkg::SLOW_LOW_PULSES
    |=> target_slow)
    else $error("slow request not recognised");
  chk_osc_free_ext: assert property (strap_done && src_ext |=> $changed(osc_buffer_out_o))
    else $error("oscillator stalled in external mode");

  cov_stop: cover property ($rose(stopped));
  cov_slow: cover property ($rose(is_slow));
  cov_ready: cover property ($rose(ready_o));
  cov_sync: cover property ($fell(sync_active));

endmodule

// [rtl/div_counter.sv]
module div_counter #(
  parameter logic [3:0] MOD = clock_gen_pkg::CLK_DIV_MOD
) (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic count_en_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic [3:0] load_val_i,
  output logic [3:0] count_o
);

  logic [3:0] wrap_count;
  logic [3:0] next_count;

  assign wrap_count = (count_o == MOD - 4'h1) ? 4'h0 : count_o + 4'h1;
  // clear inhibits counting
  assign next_count = clear_i ? clock_gen_pkg::CNT_CLEAR_VAL :
                      load_i ? load_val_i :
                      count_en_i ? wrap_count : count_o;

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      count_o <= clock_gen_pkg::CNT_RESET_VAL;
    end else begin
      count_o <= next_count;
    end
  end

endmodule
